// File: include/tmsd_pkg.sv
// constants and types for the test mode strap decoder
package tmsd_pkg;

    // operating and test modes
    typedef enum logic [2:0] {
        TMSD_MODE_NORMAL,
        TMSD_MODE_TEST_ROM,
        TMSD_MODE_OSC_BYPASS,
        TMSD_MODE_OSC_TEST,
        TMSD_MODE_ICE,
        TMSD_MODE_SYS_TEST
    } tmsd_mode_e;

    // boot bus width codes
    typedef enum logic [1:0] {
        TMSD_BOOT_32,
        TMSD_BOOT_8,
        TMSD_BOOT_16
    } tmsd_boot_e;

    localparam int          TMSD_ADDR_W       = 4;
    localparam int          TMSD_DATA_W       = 32;
    localparam int          TMSD_STRB_W       = 4;

    // register byte offsets
    localparam logic [3:0]  TMSD_OFF_STATUS   = 4'h0;
    localparam logic [3:0]  TMSD_OFF_CTRL     = 4'h4;
    localparam logic [3:0]  TMSD_OFF_STRAP    = 4'h8;

    // status fields
    localparam int          TMSD_ST_MODE_LSB  = 0;
    localparam int          TMSD_ST_BOOT_LSB  = 3;
    localparam int          TMSD_ST_PINTEST   = 5;
    localparam int          TMSD_ST_FROZEN    = 6;
    localparam int          TMSD_ST_TSEL0     = 7;
    localparam int          TMSD_ST_TSEL1     = 8;

    // control fields and reset value
    localparam int          TMSD_CTRL_PINTEST = 0;
    localparam logic        TMSD_CTRL_RST     = 1'b0;

    // captured strap fields
    localparam int          TMSD_SP_MEDCHG    = 0;
    localparam int          TMSD_SP_PE0       = 1;
    localparam int          TMSD_SP_PE1       = 2;
    localparam int          TMSD_SP_URESET    = 3;

    // port A pins driving the PLL under oscillator/PLL test
    localparam int          TMSD_PA_PLLBP     = 0;
    localparam int          TMSD_PA_PLLON     = 3;
    localparam int          TMSD_PA_XTLON     = 4;
    localparam int          TMSD_PA_TSEL      = 5;

    // column pins carrying clocks under oscillator/PLL test
    localparam int          TMSD_COL_RTCCLK   = 0;
    localparam int          TMSD_COL_CLK1HZ   = 1;
    localparam int          TMSD_COL_OSC36    = 2;
    localparam int          TMSD_COL_CLK576K  = 4;
    localparam int          TMSD_COL_VREF     = 6;

    localparam logic [1:0]  TMSD_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  TMSD_RESP_SLVERR  = 2'h2;

endpackage : tmsd_pkg

// File: include/tmsd_mode_if.sv
// strap and test-select levels in, decoded mode out
`timescale 1ns/1ns
interface tmsd_mode_if;
    logic                  media_change_strap_n;
    logic                  port_e_bit0_strap;
    logic                  port_e_bit1_strap;
    logic                  user_reset_strap_n;
    logic                  test_select0_n;
    logic                  test_select1_n;
    tmsd_pkg::tmsd_mode_e  mode;
    tmsd_pkg::tmsd_boot_e  boot;

    modport src (output media_change_strap_n, port_e_bit0_strap, port_e_bit1_strap,
                 user_reset_strap_n, test_select0_n, test_select1_n, input mode, boot);
    modport dec (input media_change_strap_n, port_e_bit0_strap, port_e_bit1_strap,
                 user_reset_strap_n, test_select0_n, test_select1_n, output mode, boot);
endinterface : tmsd_mode_if

// File: rtl/tmsd_mode_decoder.sv
// combinational mode and boot width decoder
`timescale 1ns/1ns
module tmsd_mode_decoder (
    tmsd_mode_if.dec  mif
);

    always_comb begin
        mif.mode = tmsd_pkg::TMSD_MODE_NORMAL;
        // test selects are live levels
        case ({mif.test_select0_n, mif.test_select1_n})
            2'b11: begin
                if (mif.media_change_strap_n) begin
                    mif.mode = tmsd_pkg::TMSD_MODE_NORMAL;
                end else begin
                    mif.mode = tmsd_pkg::TMSD_MODE_TEST_ROM;
                end
            end
            2'b10: begin
                mif.mode = tmsd_pkg::TMSD_MODE_OSC_BYPASS;
            end
            2'b01: begin
                // latched user reset high here is undefined: fall back to normal
                if (!mif.user_reset_strap_n) begin
                    mif.mode = tmsd_pkg::TMSD_MODE_OSC_TEST;
                end else begin
                    mif.mode = tmsd_pkg::TMSD_MODE_NORMAL;
                end
            end
            default: begin
                if (mif.user_reset_strap_n) begin
                    mif.mode = tmsd_pkg::TMSD_MODE_ICE;
                end else begin
                    mif.mode = tmsd_pkg::TMSD_MODE_SYS_TEST;
                end
            end
        endcase
    end

    always_comb begin
        mif.boot = tmsd_pkg::TMSD_BOOT_32;
        case ({mif.port_e_bit1_strap, mif.port_e_bit0_strap})
            2'b01:   mif.boot = tmsd_pkg::TMSD_BOOT_8;
            2'b10:   mif.boot = tmsd_pkg::TMSD_BOOT_16;
            default: mif.boot = tmsd_pkg::TMSD_BOOT_32;
        endcase
    end

endmodule : tmsd_mode_decoder

// File: rtl/tmsd_top.sv
// test mode strap decoder with AXI4-Lite status and control
//
// Summary of operation
// - After release strap pins are free; captured strap values stay fixed, mode follows the live selects.
// - Both selects high, media strap high: normal boot, width from port E straps.
// - Both selects high, media strap low: alternative test ROM boot, other straps ignored.
// - Select 0 high, select 1 low: oscillator/PLL bypass, all straps ignored.
// - Select 0 low, select 1 high, user reset strap low: oscillator/PLL test.
// - Both selects low: emulation if user reset strap high, else system test.
// - System test places every output buffer in high impedance.
// - Input-pin drivers enabled only while pin test is active.
// - Oscillator/PLL test repurposes port A and column pins for test signals.
// - System test disables buffers asynchronously, internal state untouched.
// - Debug logic enabled only in emulation mode.
// - Bypass disables oscillators and PLL; crystal pins become direct clock inputs.
// - Oscillator/PLL test holds logic static except ripple counter and clock chain.
`timescale 1ns/1ns
module tmsd_top #(
    parameter int NUM_PADS    = 8,
    parameter int NUM_IN_PINS = 8,
    parameter int PORT_A_W    = 8,
    parameter int COL_W       = 8
) (
    input  wire logic                                 clock_in,
    input  wire logic                                 nrst_in,
    // straps and test selects
    input  wire logic                                 media_change_strap_n_in,
    input  wire logic                                 port_e_bit0_strap_in,
    input  wire logic                                 port_e_bit1_strap_in,
    input  wire logic                                 user_reset_strap_n_in,
    input  wire logic                                 test_select0_n_in,
    input  wire logic                                 test_select1_n_in,
    // AXI4-Lite slave
    input  wire logic [tmsd_pkg::TMSD_ADDR_W-1:0]     s_axi_awaddr_in,
    input  wire logic                                 s_axi_awvalid_in,
    output logic                                      s_axi_awready_out,
    input  wire logic [tmsd_pkg::TMSD_DATA_W-1:0]     s_axi_wdata_in,
    input  wire logic [tmsd_pkg::TMSD_STRB_W-1:0]     s_axi_wstrb_in,
    input  wire logic                                 s_axi_wvalid_in,
    output logic                                      s_axi_wready_out,
    output logic [1:0]                                s_axi_bresp_out,
    output logic                                      s_axi_bvalid_out,
    input  wire logic                                 s_axi_bready_in,
    input  wire logic [tmsd_pkg::TMSD_ADDR_W-1:0]     s_axi_araddr_in,
    input  wire logic                                 s_axi_arvalid_in,
    output logic                                      s_axi_arready_out,
    output logic [tmsd_pkg::TMSD_DATA_W-1:0]          s_axi_rdata_out,
    output logic [1:0]                                s_axi_rresp_out,
    output logic                                      s_axi_rvalid_out,
    input  wire logic                                 s_axi_rready_in,
    // pad driver enables
    input  wire logic [NUM_PADS-1:0]                  pad_core_oe_in,
    output logic      [NUM_PADS-1:0]                  pad_oe_out,
    input  wire logic [NUM_IN_PINS-1:0]               in_pin_core_oe_in,
    output logic      [NUM_IN_PINS-1:0]               in_pin_oe_out,
    // decoded mode
    output logic [2:0]                                mode_out,
    output logic [1:0]                                boot_width_out,
    output logic                                      test_rom_boot_out,
    output logic                                      in_circuit_emulation_mode_out,
    output logic                                      debug_enable_out,
    output logic                                      system_test_out,
    // clock block control
    output logic                                      osc_enable_out,
    output logic                                      pll_enable_out,
    output logic                                      ext_clock_direct_out,
    output logic                                      core_clock_hold_out,
    output logic                                      ripple_rtc_run_out,
    // oscillator/PLL test pin multiplexing
    input  wire logic [PORT_A_W-1:0]                  port_a_in,
    output logic                                      pll_test_sel_out,
    output logic                                      pll_xtal_on_out,
    output logic                                      pll_on_out,
    output logic                                      pll_bypass_out,
    input  wire logic [COL_W-1:0]                     col_func_in,
    input  wire logic                                 rtc_osc_clk_in,
    input  wire logic                                 rtc_1hz_clk_in,
    input  wire logic                                 pll_main_clk_in,
    input  wire logic                                 clk_576k_in,
    input  wire logic                                 pll_vref_clk_in,
    output logic      [COL_W-1:0]                     col_out
);

    localparam int RIDX_W = 2;
    localparam logic [RIDX_W-1:0] RIDX_STATUS = 2'h0;
    localparam logic [RIDX_W-1:0] RIDX_CTRL   = 2'h1;
    localparam logic [RIDX_W-1:0] RIDX_STRAP  = 2'h2;
    localparam logic [RIDX_W-1:0] RIDX_NONE   = 2'h3;

    // strap capture
    logic        straps_frozen_q;
    logic [3:0]  strap_q;
    logic [3:0]  strap_live;
    logic [3:0]  strap_eff;

    assign strap_live[tmsd_pkg::TMSD_SP_MEDCHG] = media_change_strap_n_in;
    assign strap_live[tmsd_pkg::TMSD_SP_PE0]    = port_e_bit0_strap_in;
    assign strap_live[tmsd_pkg::TMSD_SP_PE1]    = port_e_bit1_strap_in;
    assign strap_live[tmsd_pkg::TMSD_SP_URESET] = user_reset_strap_n_in;

    // cleared by reset, set at the first edge after release
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            straps_frozen_q <= 1'b0;
        end else begin
            straps_frozen_q <= 1'b1;
        end
    end

    // no reset: tracks the pins until frozen, last sample at the first edge after release
    always_ff @(posedge clock_in) begin
        if (!straps_frozen_q) begin
            strap_q <= strap_live;
        end
    end

    // while reset is held the pins decode directly; afterwards only the capture
    assign strap_eff = straps_frozen_q ? strap_q : strap_live;

    // mode decode
    tmsd_mode_if mif ();

    assign mif.media_change_strap_n = strap_eff[tmsd_pkg::TMSD_SP_MEDCHG];
    assign mif.port_e_bit0_strap    = strap_eff[tmsd_pkg::TMSD_SP_PE0];
    assign mif.port_e_bit1_strap    = strap_eff[tmsd_pkg::TMSD_SP_PE1];
    assign mif.user_reset_strap_n   = strap_eff[tmsd_pkg::TMSD_SP_URESET];
    assign mif.test_select0_n       = test_select0_n_in;
    assign mif.test_select1_n       = test_select1_n_in;

    tmsd_mode_decoder u_decoder (
        .mif (mif)
    );

    logic is_normal;
    logic is_sys_test;
    logic is_osc_test;
    logic is_bypass;
    logic is_ice;
    logic pin_test_active;
    logic ctrl_pin_test_q;

    assign is_normal   = (mif.mode == tmsd_pkg::TMSD_MODE_NORMAL);
    assign is_sys_test = (mif.mode == tmsd_pkg::TMSD_MODE_SYS_TEST);
    assign is_osc_test = (mif.mode == tmsd_pkg::TMSD_MODE_OSC_TEST);
    assign is_bypass   = (mif.mode == tmsd_pkg::TMSD_MODE_OSC_BYPASS);
    assign is_ice      = (mif.mode == tmsd_pkg::TMSD_MODE_ICE);

    assign pin_test_active = ctrl_pin_test_q && !is_sys_test;

    // pure combinational path from the live selects: no clock involved
    assign pad_oe_out    = is_sys_test ? '0 : pad_core_oe_in;
    assign in_pin_oe_out = pin_test_active ? in_pin_core_oe_in : '0;

    assign mode_out                      = 3'(mif.mode);
    assign boot_width_out                = is_normal ? 2'(mif.boot) : 2'(tmsd_pkg::TMSD_BOOT_32);
    assign test_rom_boot_out             = (mif.mode == tmsd_pkg::TMSD_MODE_TEST_ROM);
    assign in_circuit_emulation_mode_out = is_ice;
    assign debug_enable_out              = is_ice;
    assign system_test_out               = is_sys_test;
    assign osc_enable_out                = !is_bypass;
    assign pll_enable_out                = !is_bypass;
    assign ext_clock_direct_out          = is_bypass;
    assign core_clock_hold_out           = is_osc_test;
    assign ripple_rtc_run_out            = 1'b1;

    // oscillator/PLL test pin multiplexing
    logic [3:0]       pll_ctl_q;
    logic [COL_W-1:0] col_d;
    logic [COL_W-1:0] col_q;

    // port A select, crystal and PLL-on bits are inverted so an all-zero port gives the PLL its default state
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pll_ctl_q <= 4'h0;
        end else if (is_osc_test) begin
            pll_ctl_q <= {~port_a_in[tmsd_pkg::TMSD_PA_TSEL],
                          ~port_a_in[tmsd_pkg::TMSD_PA_XTLON],
                          ~port_a_in[tmsd_pkg::TMSD_PA_PLLON],
                          port_a_in[tmsd_pkg::TMSD_PA_PLLBP]};
        end else begin
            pll_ctl_q <= 4'h0;
        end
    end

    assign pll_test_sel_out = pll_ctl_q[3];
    assign pll_xtal_on_out  = pll_ctl_q[2];
    assign pll_on_out       = pll_ctl_q[1];
    assign pll_bypass_out   = pll_ctl_q[0];

    always_comb begin
        col_d = col_func_in;
        if (is_osc_test) begin
            col_d[tmsd_pkg::TMSD_COL_RTCCLK]  = rtc_osc_clk_in;
            col_d[tmsd_pkg::TMSD_COL_CLK1HZ]  = rtc_1hz_clk_in;
            col_d[tmsd_pkg::TMSD_COL_OSC36]   = pll_main_clk_in;
            col_d[tmsd_pkg::TMSD_COL_CLK576K] = clk_576k_in;
            col_d[tmsd_pkg::TMSD_COL_VREF]    = pll_vref_clk_in;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            col_q <= '0;
        end else begin
            col_q <= col_d;
        end
    end

    assign col_out = col_q;

    // AXI4-Lite slave
    function automatic logic [RIDX_W-1:0] reg_index(input logic [tmsd_pkg::TMSD_ADDR_W-1:0] addr);
        if (addr == tmsd_pkg::TMSD_OFF_STATUS) begin
            return RIDX_STATUS;
        end else if (addr == tmsd_pkg::TMSD_OFF_CTRL) begin
            return RIDX_CTRL;
        end else if (addr == tmsd_pkg::TMSD_OFF_STRAP) begin
            return RIDX_STRAP;
        end else begin
            return RIDX_NONE;
        end
    endfunction : reg_index

    logic                              aw_hold_q;
    logic [tmsd_pkg::TMSD_ADDR_W-1:0]  awaddr_q;
    logic                              w_hold_q;
    logic [tmsd_pkg::TMSD_DATA_W-1:0]  wdata_q;
    logic [tmsd_pkg::TMSD_STRB_W-1:0]  wstrb_q;
    logic                              bvalid_q;
    logic [1:0]                        bresp_q;
    logic                              rvalid_q;
    logic [1:0]                        rresp_q;
    logic [tmsd_pkg::TMSD_DATA_W-1:0]  rdata_q;
    logic                              do_write;
    logic                              ctrl_hit;

    assign s_axi_awready_out = !aw_hold_q && !bvalid_q;
    assign s_axi_wready_out  = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;
    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rresp_out   = rresp_q;
    assign s_axi_rdata_out   = rdata_q;

    assign do_write = aw_hold_q && w_hold_q;
    assign ctrl_hit = do_write && (reg_index(awaddr_q) == RIDX_CTRL);

    // address and data are taken in either order and held until both exist
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr_in;
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            w_hold_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata_in;
            wstrb_q  <= s_axi_wstrb_in;
        end else if (do_write) begin
            w_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bvalid_q <= 1'b0;
            bresp_q  <= tmsd_pkg::TMSD_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (reg_index(awaddr_q) == RIDX_NONE) ? tmsd_pkg::TMSD_RESP_SLVERR
                                                           : tmsd_pkg::TMSD_RESP_OKAY;
        end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    // status and strap registers are read-only; writes to them are ignored
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_pin_test_q <= tmsd_pkg::TMSD_CTRL_RST;
        end else if (ctrl_hit && wstrb_q[0]) begin
            ctrl_pin_test_q <= wdata_q[tmsd_pkg::TMSD_CTRL_PINTEST];
        end
    end

    logic [tmsd_pkg::TMSD_DATA_W-1:0] status_word;
    logic [tmsd_pkg::TMSD_DATA_W-1:0] read_word;

    always_comb begin
        status_word = '0;
        status_word[tmsd_pkg::TMSD_ST_MODE_LSB +: 3] = mode_out;
        status_word[tmsd_pkg::TMSD_ST_BOOT_LSB +: 2] = boot_width_out;
        status_word[tmsd_pkg::TMSD_ST_PINTEST]       = pin_test_active;
        status_word[tmsd_pkg::TMSD_ST_FROZEN]        = straps_frozen_q;
        status_word[tmsd_pkg::TMSD_ST_TSEL0]         = test_select0_n_in;
        status_word[tmsd_pkg::TMSD_ST_TSEL1]         = test_select1_n_in;
    end

    always_comb begin
        read_word = '0;
        case (reg_index(s_axi_araddr_in))
            RIDX_STATUS: read_word = status_word;
            RIDX_CTRL:   read_word[tmsd_pkg::TMSD_CTRL_PINTEST] = ctrl_pin_test_q;
            RIDX_STRAP:  read_word[3:0] = strap_eff;
            default:     read_word = '0;
        endcase
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rvalid_q <= 1'b0;
            rresp_q  <= tmsd_pkg::TMSD_RESP_OKAY;
            rdata_q  <= '0;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_q <= 1'b1;
            rdata_q  <= read_word;
            rresp_q  <= (reg_index(s_axi_araddr_in) == RIDX_NONE) ? tmsd_pkg::TMSD_RESP_SLVERR
                                                                  : tmsd_pkg::TMSD_RESP_OKAY;
        end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule : tmsd_top

// File: sim/tmsd_top_chk.sv
// mode decode and pad enable assertions for the strap decoder
`timescale 1ns/1ns
module tmsd_chk #(
    parameter int NUM_PADS    = 8,
    parameter int NUM_IN_PINS = 8
) (
    input wire logic                   clock_in,
    input wire logic                   nrst_in,
    input wire logic                   test_select0_n_in,
    input wire logic                   test_select1_n_in,
    input wire logic [NUM_PADS-1:0]    pad_oe_out,
    input wire logic [NUM_IN_PINS-1:0] in_pin_oe_out,
    input wire logic [2:0]             mode_out,
    input wire logic [1:0]             boot_width_out,
    input wire logic                   debug_enable_out,
    input wire logic                   system_test_out,
    input wire logic                   osc_enable_out,
    input wire logic                   ext_clock_direct_out,
    input wire logic                   core_clock_hold_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    a_bypass_sel: assert property (test_select0_n_in && !test_select1_n_in |-> mode_out == 3'h2)
        else $error("bypass not selected");
    a_both_low: assert property (!test_select0_n_in && !test_select1_n_in |-> mode_out inside {3'h4, 3'h5})
        else $error("both selects low gave wrong mode");
    a_hiz_pads: assert property (system_test_out |-> pad_oe_out == '0)
        else $error("pad driven in system test");
    a_pin_gate: assert property (system_test_out |-> in_pin_oe_out == '0)
        else $error("input pin driven in system test");
    a_debug_ice: assert property (debug_enable_out == (mode_out == 3'h4))
        else $error("debug enable mismatch");
    a_bypass_clk: assert property (mode_out == 3'h2 |-> ext_clock_direct_out && !osc_enable_out)
        else $error("bypass clocking wrong");
    a_osc_hold: assert property (core_clock_hold_out == (mode_out == 3'h3))
        else $error("core hold mismatch");
    a_mode_frozen: assert property ($past(nrst_in, 2) && $past(nrst_in)
        && $stable({test_select0_n_in, test_select1_n_in}) |-> $stable(mode_out))
        else $error("mode moved without select change");
    a_boot_other: assert property (mode_out != 3'h0 |-> boot_width_out == 2'h0)
        else $error("boot width outside normal");
    cover property (mode_out == 3'h3);
    cover property (system_test_out);
    cover property (debug_enable_out);
endmodule : tmsd_chk

bind tmsd_top tmsd_chk #(.NUM_PADS(NUM_PADS), .NUM_IN_PINS(NUM_IN_PINS)) u_chk (
    .clock_in(clock_in), .nrst_in(nrst_in), .test_select0_n_in(test_select0_n_in),
    .test_select1_n_in(test_select1_n_in), .pad_oe_out(pad_oe_out), .in_pin_oe_out(in_pin_oe_out),
    .mode_out(mode_out), .boot_width_out(boot_width_out), .debug_enable_out(debug_enable_out),
    .system_test_out(system_test_out), .osc_enable_out(osc_enable_out),
    .ext_clock_direct_out(ext_clock_direct_out), .core_clock_hold_out(core_clock_hold_out));

// File: sim/tmsd_strap_model.sv
// board straps: fixed code in reset and for three edges after release, functional toggling after
`timescale 1ns/1ns
module tmsd_strap_model (
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    input  wire logic [3:0] code_in,
    output logic      [3:0] strap_out
);
    logic [1:0] hold_q;
    logic       tgl_q;
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hold_q <= 2'h0;
            tgl_q  <= 1'b0;
        end else begin
            hold_q <= (hold_q == 2'h3) ? hold_q : hold_q + 2'h1;
            tgl_q  <= ~tgl_q;
        end
    end
    assign strap_out = (hold_q != 2'h3) ? code_in : ~code_in ^ {4{tgl_q}};
endmodule : tmsd_strap_model

// File: sim/test_mode_strap_decoder_tb.sv
// self-checking bench for the strap decoder
`timescale 1ns/1ns
module test_mode_strap_decoder_tb;
    logic        clock_in = 1'b0, nrst_in = 1'b0, t0 = 1'b1, t1 = 1'b1, awv = 1'b0, wv = 1'b0;
    logic        bready = 1'b0, arv = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, code = 4'h0, straps, flg, pll;
    logic [31:0] wdata = 32'h0, rnd = 32'h9336, rdata, rd, rp;
    logic [7:0]  pad_oe, pin_oe, col;
    logic [2:0]  mode;
    logic [1:0]  boot, bresp, rresp, rr;
    int          err_total = 0, checked = 0, m;
    initial forever #2 clock_in = ~clock_in;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    always @(posedge clock_in) rnd <= lfsr(rnd);
    tmsd_strap_model u_strap (.clock_in(clock_in), .nrst_in(nrst_in), .code_in(code), .strap_out(straps));
    tmsd_top u_dut (.clock_in(clock_in), .nrst_in(nrst_in), .media_change_strap_n_in(straps[0]),
        .port_e_bit0_strap_in(straps[1]), .port_e_bit1_strap_in(straps[2]), .user_reset_strap_n_in(straps[3]),
        .test_select0_n_in(t0), .test_select1_n_in(t1), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pad_core_oe_in(rnd[31:24]),
        .pad_oe_out(pad_oe), .in_pin_core_oe_in(rnd[23:16]), .in_pin_oe_out(pin_oe), .mode_out(mode),
        .boot_width_out(boot), .test_rom_boot_out(flg[0]), .in_circuit_emulation_mode_out(flg[1]),
        .debug_enable_out(), .system_test_out(), .osc_enable_out(), .pll_enable_out(flg[2]),
        .ext_clock_direct_out(), .core_clock_hold_out(), .ripple_rtc_run_out(flg[3]), .port_a_in(rnd[7:0]),
        .pll_test_sel_out(pll[3]), .pll_xtal_on_out(pll[2]), .pll_on_out(pll[1]), .pll_bypass_out(pll[0]),
        .col_func_in(rnd[15:8]), .rtc_osc_clk_in(rnd[3]), .rtc_1hz_clk_in(rnd[9]), .pll_main_clk_in(rnd[12]),
        .clk_576k_in(rnd[17]), .pll_vref_clk_in(rnd[26]), .col_out(col));
    task test_done;
        if (err_total == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task axw(input logic [3:0] a, input logic [31:0] d);
        int n;
        awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clock_in);
            if (awv && awready) awv <= 1'b0;
            if (wv && wready) wv <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 40) begin err_total++; test_done(); end
    endtask : axw
    task axr(input logic [3:0] a);
        int n;
        araddr <= a; arv <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clock_in);
            if (arv && arready) arv <= 1'b0;
            if (rvalid) begin rd = rdata; rr = rresp; break; end
        end
        rready <= 1'b0;
        if (n == 40) begin err_total++; test_done(); end
    endtask : axr
    function automatic int em(input logic a, input logic b, input logic [3:0] c);
        if (a && b) return c[0] ? 0 : 1;
        if (a) return 2;
        if (b) return c[3] ? 0 : 3;
        return c[3] ? 4 : 5;
    endfunction : em
    initial begin
        for (int c = 0; c < 16; c++) begin
            @(posedge clock_in);
            code <= c[3:0];
            nrst_in <= 1'b0;
            repeat (6) @(posedge clock_in);
            nrst_in <= 1'b1;
            repeat (4) @(posedge clock_in);
            axw(tmsd_pkg::TMSD_OFF_CTRL, {31'h0, c[0]});
            for (int t = 0; t < 4; t++) begin
                t0 <= t[0];
                t1 <= t[1];
                @(posedge clock_in);
                m = em(t[0], t[1], c[3:0]);
                chk({29'h0, mode}, m);
                chk({24'h0, pad_oe}, (m == 5) ? 32'h0 : {24'h0, rnd[31:24]});
                chk({24'h0, pin_oe}, (c[0] && m != 5) ? {24'h0, rnd[23:16]} : 32'h0);
                chk({28'h0, flg}, {28'h0, 1'b1, m != 2, m == 4, m == 1});
                if (t == 3) chk({30'h0, boot}, !c[0] ? 0 : (c[2:1] == 2'h1) ? 1 : (c[2:1] == 2'h2) ? 2 : 0);
                if (t == 3) chk({20'h0, col, pll}, c[3] ? {20'h0, rp[15:8], 4'h0} :
                    {rp[15], rp[26], rp[13], rp[17], rp[11], rp[12], rp[9], rp[3], ~rp[5], ~rp[4], ~rp[3], rp[0]});
                rp = rnd;
            end
            axr(tmsd_pkg::TMSD_OFF_STRAP);
            chk(rd, c);
        end
        @(posedge clock_in);
        axr(4'hC);
        chk({30'h0, rr}, {30'h0, tmsd_pkg::TMSD_RESP_SLVERR});
        test_done();
    end
endmodule : test_mode_strap_decoder_tb
